/* wut_defines.svh */
// Constants for the waveform update timing block: offsets, fields, resets, timing.
`ifndef WUT_DEFINES_SVH
`define WUT_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define WUT_OFS_CTRL       8'h00
`define WUT_OFS_TRIG_CFG   8'h04
`define WUT_OFS_UPD_CFG    8'h08
`define WUT_OFS_CLK_CFG    8'h0c
`define WUT_OFS_INTERVAL   8'h10
`define WUT_OFS_POINTS     8'h14
`define WUT_OFS_STATUS     8'h18
`define WUT_OFS_IRQ_STAT   8'h1c
`define WUT_OFS_IRQ_EN     8'h20
`define WUT_OFS_IRQ_CLR    8'h24

// ==========================================================================
// Field positions
`define WUT_CTRL_ARM       0
`define WUT_CTRL_STOP      1
`define WUT_CTRL_GATE      2
`define WUT_CTRL_POSTED    3
`define WUT_CTRL_OUTEN     4
`define WUT_CFG_PIN_LSB    0
`define WUT_CFG_PIN_MSB    3
`define WUT_CFG_POL        4
`define WUT_CFG_EXT        5
`define WUT_CFG_SLOW       6

// ==========================================================================
// Reset values
`define WUT_RST_WORD       32'h0000_0000
`define WUT_RST_COUNT      16'h0000

// ==========================================================================
// Timing
`define WUT_PFI_N          10
`define WUT_SYS_HZ         10000000
`define WUT_CLK_NS         100
`define WUT_TB_FAST_HZ     20000000
`define WUT_TB_SLOW_HZ     100000
`define WUT_TRIG_PW_MIN_NS 50
`define WUT_UPD_PW_MIN_NS  300
`define WUT_TRIG_PW_CYC    ((`WUT_TRIG_PW_MIN_NS + `WUT_CLK_NS - 1) / `WUT_CLK_NS)
`define WUT_UPD_PW_CYC     ((`WUT_UPD_PW_MIN_NS + `WUT_CLK_NS - 1) / `WUT_CLK_NS)
`define WUT_TB_SLOW_CYC    (`WUT_SYS_HZ / `WUT_TB_SLOW_HZ)
`define WUT_TB_FAST_CYC    ((`WUT_SYS_HZ / `WUT_TB_FAST_HZ) < 1 ? 1 : (`WUT_SYS_HZ / `WUT_TB_FAST_HZ))

`endif

/* wut_pfi_drv.sv */
// Model of the external instruments that drive the programmable input pins.
`timescale 1ns/1ps
`default_nettype none
`include "wut_defines.svh"

module wut_pfi_drv (
    // Clock
    input  wire logic             clk_sys,
    // Pins toward the block
    output logic [`WUT_PFI_N-1:0] pfi_in
);
    initial pfi_in = '0;

    // ======================================================================
    // Park a pin at its inactive level (pol 1 = active low)
    task automatic park(input int p, input logic pol);
        @(posedge clk_sys);
        pfi_in[p] <= pol;
    endtask : park

    // One strobe, then a quiet gap so fresh data can reach the latches
    task automatic strobe(input int p, input logic pol);
        @(posedge clk_sys);
        pfi_in[p] <= ~pol;
        repeat (2) @(posedge clk_sys);
        pfi_in[p] <= pol;
        repeat (4) @(posedge clk_sys);
    endtask : strobe

    // Interval clock: 100 ns phases, well inside the rate limit
    task automatic ticks(input int p, input logic pol, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            pfi_in[p] <= ~pol;
            @(posedge clk_sys);
            pfi_in[p] <= pol;
        end
    endtask : ticks
endmodule : wut_pfi_drv
`default_nettype wire

/* wut_pfi_sel.sv */
// Programmable input selector with polarity and rising-edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "wut_defines.svh"

module wut_pfi_sel
    import wut_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // Pins and selection
    input  wire logic [`WUT_PFI_N-1:0] pfi_in,
    input  wire wut_sel_t              sel,
    // Selected signal
    output logic                       lvl,
    output logic                       rise
);

    wut_pfi_state_t st_reg;
    wut_pfi_state_t st_next;
    logic           raw;

    // ======================================================================
    // Pick the pin, fold polarity so that active is always high
    always_comb begin
        raw          = (sel.pin < 4'(`WUT_PFI_N)) ? pfi_in[sel.pin] : 1'b0;
        st_next.lvl  = raw ^ sel.pol;
        // Active-going change; a pin switch can fake one, so switch while idle
        st_next.rise = st_next.lvl & ~st_reg.lvl;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lvl  = st_reg.lvl;
    assign rise = st_reg.rise;

endmodule : wut_pfi_sel

`default_nettype wire

/* wut_pkg.sv */
// Types shared by the waveform update timing block.
package wut_pkg;

    // ======================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        WUT_IDLE,
        WUT_ARMED,
        WUT_RUN
    } wut_state_t;

    // ======================================================================
    // Input pin selection: pin number and polarity (1 = falling / active low)
    typedef struct packed {
        logic [3:0] pin;
        logic       pol;
    } wut_sel_t;

    // Event bits of the interrupt registers
    typedef struct packed {
        logic done;
        logic upd;
        logic trig;
    } wut_evt_t;

    // State of one input selector
    typedef struct packed {
        logic lvl;
        logic rise;
    } wut_pfi_state_t;

    // State of the whole timing block
    typedef struct packed {
        wut_state_t state;
        logic       gate;
        logic       posted;
        logic       outen;
        wut_sel_t   trig_sel;
        wut_sel_t   upd_sel;
        logic       upd_ext;
        wut_sel_t   clk_sel;
        logic       clk_ext;
        logic       clk_slow;
        logic [15:0] interval;
        logic [15:0] points;
        logic [15:0] left;
        logic [15:0] ui_cnt;
        logic [7:0]  tb_cnt;
        logic [1:0]  trig_cnt;
        logic [1:0]  upd_cnt;
        logic        dac_load;
        logic        done;
        wut_evt_t    stat;
        wut_evt_t    en;
        logic [31:0] rdata;
    } wut_state_s_t;

endpackage : wut_pkg

/* wut_waveform_update_timing.sv */
// Waveform start trigger, update-interval counter and update strobe logic.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "wut_defines.svh"

module wut_waveform_update_timing
    import wut_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    // Programmable function input pins
    input  wire logic [`WUT_PFI_N-1:0] pfi_in,
    // Trigger echo pin
    output logic                       trig_echo_o,
    output logic                       trig_echo_oe,
    // Update echo pin, active low
    output logic                       upd_echo_n_o,
    output logic                       upd_echo_n_oe,
    // Converter control
    output logic                       dac_load,
    output logic                       dac_posted_mode,
    // Interrupt
    output logic                       irq
);

    // ======================================================================
    // Declarations
    wut_state_s_t s_reg;
    wut_state_s_t s_next;
    wut_sel_t [2:0] sel_arr;
    logic [2:0]     sel_lvl;
    logic [2:0]     sel_rise;
    logic           trig_edge;
    logic           upd_edge;
    logic           clk_rise;
    logic           launch;
    logic           tb_tick;
    logic           ui_tick;
    logic           int_upd;
    logic           upd_req;
    logic           upd_apply;
    logic           finish;
    logic           sw_stop;
    logic [7:0]     tb_div;
    wut_evt_t       evt;
    wut_evt_t       clr;
    logic           wr_ctrl;

    // Unpack a configuration word into pin and polarity
    function automatic wut_sel_t cfg_sel(input logic [31:0] w);
        wut_sel_t r;
        r.pin = w[`WUT_CFG_PIN_MSB:`WUT_CFG_PIN_LSB];
        r.pol = w[`WUT_CFG_POL];
        return r;
    endfunction : cfg_sel

    // ======================================================================
    // Input selectors: trigger, update, interval clock
    assign sel_arr = {s_reg.clk_sel, s_reg.upd_sel, s_reg.trig_sel};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sel
            wut_pfi_sel u_sel (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .pfi_in  (pfi_in),
                .sel     (sel_arr[gi]),
                .lvl     (sel_lvl[gi]),
                .rise    (sel_rise[gi])
            );
        end
    endgenerate

    assign trig_edge = sel_rise[0];                  // Chosen edge of start trigger
    assign upd_edge  = sel_rise[1];                  // Chosen edge of update strobe
    assign clk_rise  = sel_rise[2];                  // Level-mode clock going active

    // ======================================================================
    // Timebase and update-interval clock
    // The 20 MHz timebase exceeds this clock, so it ticks every cycle instead
    always_comb begin
        tb_div  = s_reg.clk_slow ? 8'(`WUT_TB_SLOW_CYC) : 8'(`WUT_TB_FAST_CYC);
        tb_tick = (s_reg.tb_cnt == 8'h00);
        ui_tick = s_reg.clk_ext ? clk_rise : tb_tick; // Count clock of interval counter
    end

    // ======================================================================
    // Sequencing decisions
    always_comb begin
        wr_ctrl   = reg_wr && (reg_addr == `WUT_OFS_CTRL);
        sw_stop   = wr_ctrl && reg_wdata[`WUT_CTRL_STOP];
        launch    = (s_reg.state == WUT_ARMED) && trig_edge;
        // Internal update when the running counter expires
        int_upd   = (s_reg.state == WUT_RUN) && !s_reg.upd_ext && ui_tick
                    && (s_reg.ui_cnt <= 16'h0001);
        upd_req   = s_reg.upd_ext ? ((s_reg.state == WUT_RUN) && upd_edge) : int_upd;
        // Gate set or posted mode clear holds back the converter load
        upd_apply = upd_req && !s_reg.gate && s_reg.posted
                    && (s_reg.left != 16'h0000) && !sw_stop;
        // One more update than points closes the run
        finish    = upd_req && !s_reg.gate && (s_reg.left == 16'h0000);
        evt.trig  = launch;
        evt.upd   = upd_apply;
        evt.done  = finish;
        clr       = (reg_wr && (reg_addr == `WUT_OFS_IRQ_CLR)) ? wut_evt_t'(reg_wdata[2:0])
                                                               : wut_evt_t'(3'h0);
    end

    // ======================================================================
    // Next-state logic
    always_comb begin
        s_next = s_reg;

        // Configuration writes, one selector per function
        if (wr_ctrl) begin
            s_next.gate   = reg_wdata[`WUT_CTRL_GATE];
            s_next.posted = reg_wdata[`WUT_CTRL_POSTED];
            s_next.outen  = reg_wdata[`WUT_CTRL_OUTEN];
        end
        if (reg_wr && (reg_addr == `WUT_OFS_TRIG_CFG)) begin
            s_next.trig_sel = cfg_sel(reg_wdata);
        end
        if (reg_wr && (reg_addr == `WUT_OFS_UPD_CFG)) begin
            s_next.upd_sel = cfg_sel(reg_wdata);
            s_next.upd_ext = reg_wdata[`WUT_CFG_EXT];
        end
        if (reg_wr && (reg_addr == `WUT_OFS_CLK_CFG)) begin
            s_next.clk_sel  = cfg_sel(reg_wdata);
            s_next.clk_ext  = reg_wdata[`WUT_CFG_EXT];
            s_next.clk_slow = reg_wdata[`WUT_CFG_SLOW];
        end
        if (reg_wr && (reg_addr == `WUT_OFS_INTERVAL)) begin
            s_next.interval = reg_wdata[15:0];
        end
        if (reg_wr && (reg_addr == `WUT_OFS_POINTS)) begin
            s_next.points = reg_wdata[15:0];
        end
        if (reg_wr && (reg_addr == `WUT_OFS_IRQ_EN)) begin
            s_next.en = wut_evt_t'(reg_wdata[2:0]);
        end

        // Timebase divider runs freely so tick phase does not depend on start
        s_next.tb_cnt = (s_reg.tb_cnt >= tb_div - 8'h01) ? 8'h00 : s_reg.tb_cnt + 8'h01;

        // Sequencer
        unique case (s_reg.state)
            WUT_IDLE: begin
                if (wr_ctrl && reg_wdata[`WUT_CTRL_ARM] && !sw_stop) begin
                    s_next.state = WUT_ARMED;
                    s_next.done  = 1'b0;
                end
            end
            WUT_ARMED: begin
                if (sw_stop) begin
                    s_next.state = WUT_IDLE;
                end else if (launch) begin
                    s_next.state = WUT_RUN;
                    s_next.left  = s_reg.points;
                    // Interval counter loads on the start edge
                    s_next.ui_cnt = (s_reg.interval == 16'h0000) ? 16'h0001 : s_reg.interval;
                end
            end
            WUT_RUN: begin
                if (sw_stop || finish) begin
                    s_next.state = WUT_IDLE;
                    s_next.done  = finish;
                end else begin
                    if (!s_reg.upd_ext && ui_tick) begin
                        // Count down and reload on expiry
                        s_next.ui_cnt = int_upd ? ((s_reg.interval == 16'h0000) ? 16'h0001
                                                                                : s_reg.interval)
                                                : s_reg.ui_cnt - 16'h0001;
                    end
                    if (upd_apply) begin
                        s_next.left = s_reg.left - 16'h0001;
                    end
                end
            end
        endcase

        // Trigger echo pulse and update echo pulse
        s_next.trig_cnt = launch ? 2'(`WUT_TRIG_PW_CYC)
                                 : ((s_reg.trig_cnt != 2'h0) ? s_reg.trig_cnt - 2'h1 : 2'h0);
        s_next.upd_cnt  = upd_apply ? 2'(`WUT_UPD_PW_CYC)
                                    : ((s_reg.upd_cnt != 2'h0) ? s_reg.upd_cnt - 2'h1 : 2'h0);
        s_next.dac_load = upd_apply;

        // Sticky events; a set in the clearing cycle wins
        s_next.stat = (s_reg.stat & ~clr) | evt;

        // Read data stand one cycle after the read strobe
        s_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `WUT_OFS_CTRL:     s_next.rdata = {27'h0, s_reg.outen, s_reg.posted,
                                                   s_reg.gate, 2'h0};
                `WUT_OFS_TRIG_CFG: s_next.rdata = {27'h0, s_reg.trig_sel};
                `WUT_OFS_UPD_CFG:  s_next.rdata = {26'h0, s_reg.upd_ext, s_reg.upd_sel};
                `WUT_OFS_CLK_CFG:  s_next.rdata = {25'h0, s_reg.clk_slow, s_reg.clk_ext,
                                                   s_reg.clk_sel};
                `WUT_OFS_INTERVAL: s_next.rdata = {16'h0, s_reg.interval};
                `WUT_OFS_POINTS:   s_next.rdata = {16'h0, s_reg.points};
                `WUT_OFS_STATUS:   s_next.rdata = {s_reg.left, 13'h0, s_reg.done,
                                                   s_reg.state};
                `WUT_OFS_IRQ_STAT: s_next.rdata = {29'h0, s_reg.stat};
                `WUT_OFS_IRQ_EN:   s_next.rdata = {29'h0, s_reg.en};
                default:           s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================================
    // Outputs; only trigger and update echoes drive pins, clock has none
    assign trig_echo_o     = (s_reg.trig_cnt != 2'h0);
    assign trig_echo_oe    = s_reg.outen;
    assign upd_echo_n_o    = (s_reg.upd_cnt == 2'h0);
    assign upd_echo_n_oe   = s_reg.outen;
    assign dac_load        = s_reg.dac_load;
    assign dac_posted_mode = s_reg.posted;
    assign reg_rdata       = s_reg.rdata;
    assign irq             = |(s_reg.stat & s_reg.en);

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_trig_pulse;
        trig_echo_o ##1 !trig_echo_o;
    endsequence

    sequence s_upd_pulse;
        !upd_echo_n_o [*3];
    endsequence

    a_start_edge:   assert property (launch |=> s_reg.state == WUT_RUN)
        else $error("start edge did not begin generation");
    a_ui_load:      assert property (launch && !s_reg.upd_ext |=> s_reg.ui_cnt != 16'h0000)
        else $error("interval counter not loaded on start");
    a_trig_echo:    assert property (launch && s_reg.trig_cnt == 2'h0 |=> s_trig_pulse)
        else $error("trigger echo width wrong");
    // Echo pins may only start driving right after software enables them
    a_pins_hiz:     assert property ($rose(trig_echo_oe) || $rose(upd_echo_n_oe)
                                     |-> $past(wr_ctrl && reg_wdata[`WUT_CTRL_OUTEN]))
        else $error("echo pin driven while disabled");
    a_ext_update:   assert property (s_reg.state == WUT_RUN && s_reg.upd_ext && upd_edge
                                     && !s_reg.gate && s_reg.posted && s_reg.left != 16'h0000
                                     && !sw_stop |=> dac_load)
        else $error("external update edge ignored");
    a_upd_echo:     assert property (upd_apply |=> s_upd_pulse)
        else $error("update echo shorter than three cycles");
    a_load_cause:   assert property (dac_load |-> $past(upd_apply))
        else $error("converter load without update");
    a_gate_block:   assert property (s_reg.gate |=> !dac_load)
        else $error("update passed while gated");
    a_stop_run:     assert property (sw_stop && s_reg.state != WUT_IDLE |=> s_reg.state == WUT_IDLE)
        else $error("software stop ignored");
    a_int_source:   assert property (int_upd |-> !s_reg.upd_ext && ui_tick)
        else $error("internal update without interval clock");
    a_slow_base:    assert property (!s_reg.clk_ext && s_reg.clk_slow && ui_tick
                                     |=> !ui_tick [*8])
        else $error("slow timebase ticks too often");
    a_lvl_clock:    assert property (s_reg.clk_ext && ui_tick |-> sel_lvl[2] && !$past(sel_lvl[2]))
        else $error("clock tick not on active-going level");

endmodule : wut_waveform_update_timing

`default_nettype wire

/* wut_waveform_update_timing_tb.sv */
// Self-checking testbench for the waveform update timing block.
`timescale 1ns/1ps
`default_nettype none
`include "wut_defines.svh"

module wut_waveform_update_timing_tb;
    logic                  clk_sys;
    logic                  rstn;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_rdata;
    logic [`WUT_PFI_N-1:0] pfi_in;
    logic                  trig_echo_o;
    logic                  trig_echo_oe;
    logic                  upd_echo_n_o;
    logic                  upd_echo_n_oe;
    logic                  dac_load;
    logic                  dac_posted_mode;
    logic                  irq;
    logic [31:0]           rv;
    logic                  tpol, upol, cpol;
    int                    tp, up, cp;
    int                    bad_count = 0;
    int                    n_checks = 0;
    int                    n_load = 0;
    int                    exp_load = 0;
    int                    low_run = 0;
    int                    n_cyc = 0;
    int                    last_load = 0;
    int                    exp_gap = 0;

    wut_waveform_update_timing dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pfi_in(pfi_in), .trig_echo_o(trig_echo_o), .trig_echo_oe(trig_echo_oe),
        .upd_echo_n_o(upd_echo_n_o), .upd_echo_n_oe(upd_echo_n_oe), .dac_load(dac_load),
        .dac_posted_mode(dac_posted_mode), .irq(irq));
    wut_pfi_drv drv (.clk_sys(clk_sys), .pfi_in(pfi_in));

    // ======================================================================
    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // Loads counted at the falling edge, where registered outputs are settled
    always @(negedge clk_sys) begin
        n_cyc++;
        if (dac_load === 1'b1) begin
            n_load++;
            check({upd_echo_n_oe, upd_echo_n_o}, 32'h2);
            // Spacing of internal loads must match the programmed interval
            if (exp_gap != 0 && last_load != 0) check(n_cyc - last_load, exp_gap);
            last_load = n_cyc;
        end
        if (upd_echo_n_o === 1'b0)
            low_run++;
        else begin
            if (low_run != 0) check(low_run, 32'h3);
            low_run = 0;
        end
    end

    // ======================================================================
    // Register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // Idle edge so a following strobe is never set in this time step
        @(posedge clk_sys);
    endtask : wr

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        check(reg_rdata & m, e);
        @(posedge clk_sys);
    endtask : rdm

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic chk_irq(input logic e);
        @(negedge clk_sys);
        check(irq, e);
        @(posedge clk_sys);
    endtask : chk_irq

    // Trigger echo must be one cycle wide with the pin driven
    task automatic see_trig();
        for (int i = 0; i < 30 && trig_echo_o !== 1'b1; i++) @(negedge clk_sys);
        check({trig_echo_oe, trig_echo_o}, 32'h3);
        @(negedge clk_sys);
        check(trig_echo_o, 32'h0);
    endtask : see_trig

    // Arm, confirm nothing loads before the trigger, then fire it
    task automatic launch(input logic [31:0] ctrl);
        wr(`WUT_OFS_CTRL, ctrl);
        cyc(20);
        check(n_load, exp_load);
        fork
            drv.strobe(tp, tpol);
            see_trig();
        join
        cyc(1);
    endtask : launch

    // ======================================================================
    // Main sequence
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rstn = 1'b0;
        void'($urandom(32'hb07e));
        tp = $urandom % 10;
        up = (tp + 3) % 10;
        cp = (tp + 7) % 10;
        tpol = 1'($urandom);
        upol = 1'($urandom);
        cpol = 1'($urandom);
        // Watchdog well beyond the several hundred cycles the run needs
        fork
            begin
                cyc(20000);
                bad_count++;
                finish_test();
            end
        join_none
        cyc(4);
        rstn <= 1'b1;
        @(negedge clk_sys);
        check({trig_echo_oe, upd_echo_n_oe, upd_echo_n_o, trig_echo_o}, 32'h2);
        @(posedge clk_sys);
        drv.park(tp, tpol);
        drv.park(up, upol);
        drv.park(cp, cpol);
        // Internal updates from the fast timebase
        wr(`WUT_OFS_TRIG_CFG, (32'(tpol) << 4) | 32'(tp));
        wr(`WUT_OFS_UPD_CFG, (32'(upol) << 4) | 32'(up));
        wr(`WUT_OFS_CLK_CFG, 32'h0);
        wr(`WUT_OFS_INTERVAL, 32'h5);
        wr(`WUT_OFS_POINTS, 32'h2);
        wr(`WUT_OFS_IRQ_EN, 32'h7);
        exp_gap = 5;
        launch(32'h19);
        cyc(40);
        exp_gap = 0;
        exp_load += 2;
        check(n_load, exp_load);
        rdm(`WUT_OFS_STATUS, 32'h7, 32'h4);
        chk_irq(1'b1);
        rdm(`WUT_OFS_IRQ_STAT, 32'h7, 32'h7);
        wr(`WUT_OFS_IRQ_EN, 32'h0);
        chk_irq(1'b0);
        wr(`WUT_OFS_IRQ_EN, 32'h4);
        chk_irq(1'b1);
        wr(`WUT_OFS_IRQ_CLR, 32'h7);
        chk_irq(1'b0);
        rdm(`WUT_OFS_IRQ_STAT, 32'hffffffff, 32'h0);
        rdm(`WUT_OFS_IRQ_CLR, 32'hffffffff, 32'h0);
        rdm(8'h3c, 32'hffffffff, 32'h0);
        // Converters not in posted mode: updates refused, then software stop
        launch(32'h11);
        cyc(40);
        check({dac_posted_mode, n_load[7:0]}, {1'b0, exp_load[7:0]});
        wr(`WUT_OFS_CTRL, 32'h12);
        rdm(`WUT_OFS_STATUS, 32'h3, 32'h0);
        // External updates, first one gated off
        wr(`WUT_OFS_UPD_CFG, 32'h20 | (32'(upol) << 4) | 32'(up));
        launch(32'h1d);
        drv.strobe(up, upol);
        check(n_load, exp_load);
        wr(`WUT_OFS_CTRL, 32'h18);
        check(dac_posted_mode, 32'h1);
        repeat (2) drv.strobe(up, upol);
        exp_load += 2;
        check(n_load, exp_load);
        rdm(`WUT_OFS_STATUS, 32'h3, 32'h2);
        drv.strobe(up, upol);
        rdm(`WUT_OFS_STATUS, 32'h3, 32'h0);
        // External level-detected interval clock
        wr(`WUT_OFS_UPD_CFG, 32'h0);
        wr(`WUT_OFS_CLK_CFG, 32'h20 | (32'(cpol) << 4) | 32'(cp));
        wr(`WUT_OFS_INTERVAL, 32'h8);
        wr(`WUT_OFS_POINTS, 32'h1);
        launch(32'h19);
        drv.ticks(cp, cpol, 3);
        cyc(4);
        check(n_load, exp_load);
        drv.ticks(cp, cpol, 9);
        cyc(4);
        exp_load += 1;
        check(n_load, exp_load);
        wr(`WUT_OFS_CTRL, 32'h1a);
        // Slow 100 kHz timebase: one tick every 100 cycles
        wr(`WUT_OFS_CLK_CFG, 32'h40);
        wr(`WUT_OFS_INTERVAL, 32'h2);
        launch(32'h19);
        cyc(60);
        check(n_load, exp_load);
        cyc(180);
        exp_load += 1;
        check(n_load, exp_load);
        wr(`WUT_OFS_CTRL, 32'h1a);
        cyc(5);
        finish_test();
    end
endmodule : wut_waveform_update_timing_tb
`default_nettype wire
